// file: pkg/tpc_pkg.sv
// constants and register map of the timer pin i/o control block
package tpc_pkg;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned CNT_W_DEF = 16;
    // ========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_C5_IOC = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_C0_IOC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_C5_GR  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_C0_GR  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h10;
    // ========================================================
    // field layout
    localparam int unsigned FIELD_W     = 4;
    localparam int unsigned B_FIELD_LSB = 4;
    localparam int unsigned A_FIELD_LSB = 0;
    localparam int unsigned F_MODE      = 3;
    localparam int unsigned F_LEVEL     = 2;
    localparam int unsigned F_ACT_HI    = 1;
    localparam int unsigned F_ACT_LO    = 0;
    localparam logic [1:0]  ACT_NONE    = 2'h0;
    localparam logic [1:0]  ACT_LOW     = 2'h1;
    localparam logic [1:0]  ACT_HIGH    = 2'h2;
    localparam logic [1:0]  ACT_TOGGLE  = 2'h3;
    // ========================================================
    // status bits
    localparam int unsigned ST_CAP5  = 0;
    localparam int unsigned ST_CAP0  = 1;
    localparam int unsigned ST_PIN5  = 2;
    localparam int unsigned ST_PIN0  = 3;
    localparam int unsigned ST_OUT5  = 4;
    localparam int unsigned ST_OUT0  = 5;
    // ========================================================
    // reset values and bus answers
    localparam logic [7:0]  IOC_RESET   = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : tpc_pkg

// file: src/tpc_top.sv
// pin i/o control for channel 5 b and channel 0 a of a timer
// How it works
// - top bits 00: low start, 00 disables
// - top bits 01: pin starts high
// - action 01: drive low on match
// - action 10: drive high on match
// - action 11: toggle on every match
// - mode bit set: capture on rising edge
// - capture action 01: capture on falling edge
// - action bit one set: capture both edges
// - channel 5 ignores level bit in capture
// - channel 0 top 10: own pin source
// - channel 0 top 11: channel 1 count ticks
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module tpc_top #(
    parameter int unsigned CNT_W = tpc_pkg::CNT_W_DEF
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [tpc_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                      s_awvalid,
    output logic                           s_awready,
    input  wire logic [31:0]               s_wdata,
    input  wire logic [3:0]                s_wstrb,
    input  wire logic                      s_wvalid,
    output logic                           s_wready,
    output logic [1:0]                     s_bresp,
    output logic                           s_bvalid,
    input  wire logic                      s_bready,
    input  wire logic [tpc_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                      s_arvalid,
    output logic                           s_arready,
    output logic [31:0]                    s_rdata,
    output logic [1:0]                     s_rresp,
    output logic                           s_rvalid,
    input  wire logic                      s_rready,
    input  wire logic [CNT_W-1:0]          chan5_counter,
    input  wire logic [CNT_W-1:0]          chan0_counter,
    input  wire logic                      chan1_count_tick,
    input  wire logic                      chan5_pin_b_in,
    output logic                           chan5_pin_b_out,
    output logic                           chan5_pin_b_oe_n,
    input  wire logic                      chan0_pin_a_in,
    output logic                           chan0_pin_a_out,
    output logic                           chan0_pin_a_oe_n
);
    import tpc_pkg::*;

    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie in 1..32");
    end

    // ========================================================
    // field helpers
    function automatic logic [1:0] fld_act(input logic [3:0] f);
        fld_act = f[F_ACT_LO +: 2];
    endfunction : fld_act

    function automatic logic is_oc(input logic [3:0] f);
        is_oc = !f[F_MODE] && (fld_act(f) != ACT_NONE);
    endfunction : is_oc

    function automatic logic oc_next(input logic [3:0] f,
                                     input logic       cur);
        case (fld_act(f))
            ACT_LOW:    oc_next = 1'b0;
            ACT_HIGH:   oc_next = 1'b1;
            ACT_TOGGLE: oc_next = !cur;
            default:    oc_next = cur;
        endcase
    endfunction : oc_next

    // action bit one selects both edges, else bit zero picks falling
    function automatic logic cap_edge(input logic [3:0] f,
                                      input logic       rise,
                                      input logic       fall);
        if (f[F_ACT_HI])
            cap_edge = rise || fall;
        else if (f[F_ACT_LO])
            cap_edge = fall;
        else
            cap_edge = rise;
    endfunction : cap_edge

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFF_C5_IOC) || (a == OFF_C0_IOC) ||
                    (a == OFF_C5_GR) || (a == OFF_C0_GR) ||
                    (a == OFF_STAT);
    endfunction : is_mapped

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i])
                merge[8*i +: 8] = d[8*i +: 8];
        end
    endfunction : merge

    // ========================================================
    // axi4-lite write channel
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_hs;
    logic              w_hs;
    logic              do_write;
    logic              next_aw_got;
    logic              next_w_got;
    logic              next_bvalid;

    assign aw_hs       = s_awvalid && s_awready;
    assign w_hs        = s_wvalid && s_wready;
    assign do_write    = aw_got && w_got && !s_bvalid;
    assign next_aw_got = (aw_got || aw_hs) && !do_write;
    assign next_w_got  = (w_got || w_hs) && !do_write;
    assign next_bvalid = do_write || (s_bvalid && !s_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr   <= '0;
            w_data    <= '0;
            w_strb    <= '0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
        end else begin
            aw_got    <= next_aw_got;
            w_got     <= next_w_got;
            s_bvalid  <= next_bvalid;
            // ready is registered, so it only rises once a slot is free
            s_awready <= !next_aw_got && !next_bvalid;
            s_wready  <= !next_w_got && !next_bvalid;
            if (aw_hs)
                aw_addr <= s_awaddr;
            if (w_hs) begin
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (do_write)
                s_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    logic cfg5_wr;
    logic cfg0_wr;
    logic gr5_wr;
    logic gr0_wr;
    logic st_wr;
    logic [3:0] wf5;
    logic [3:0] wf0;

    assign cfg5_wr = do_write && aw_addr == OFF_C5_IOC && w_strb[0];
    assign cfg0_wr = do_write && aw_addr == OFF_C0_IOC && w_strb[0];
    assign gr5_wr  = do_write && aw_addr == OFF_C5_GR;
    assign gr0_wr  = do_write && aw_addr == OFF_C0_GR;
    assign st_wr   = do_write && aw_addr == OFF_STAT && w_strb[0];
    assign wf5     = w_data[B_FIELD_LSB +: FIELD_W];
    assign wf0     = w_data[A_FIELD_LSB +: FIELD_W];

    // ========================================================
    // control registers
    logic [7:0] ioc5;
    logic [7:0] ioc0;
    logic [3:0] f5;
    logic [3:0] f0;

    assign f5 = ioc5[B_FIELD_LSB +: FIELD_W];
    assign f0 = ioc0[A_FIELD_LSB +: FIELD_W];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ioc5 <= IOC_RESET;
            ioc0 <= IOC_RESET;
        end else begin
            if (cfg5_wr)
                ioc5 <= w_data[7:0];
            if (cfg0_wr)
                ioc0 <= w_data[7:0];
        end
    end

    // ========================================================
    // pin synchronisers and edge detect
    logic pin5_s1, pin5_s2, pin5_d;
    logic pin0_s1, pin0_s2, pin0_d;
    logic rise5, fall5, rise0, fall0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {pin5_s1, pin5_s2, pin5_d} <= '0;
            {pin0_s1, pin0_s2, pin0_d} <= '0;
        end else begin
            {pin5_s1, pin5_s2, pin5_d} <= {chan5_pin_b_in, pin5_s1, pin5_s2};
            {pin0_s1, pin0_s2, pin0_d} <= {chan0_pin_a_in, pin0_s1, pin0_s2};
        end
    end

    assign rise5 = pin5_s2 && !pin5_d;
    assign fall5 = !pin5_s2 && pin5_d;
    assign rise0 = pin0_s2 && !pin0_d;
    assign fall0 = !pin0_s2 && pin0_d;

    // ========================================================
    // compare match and capture events
    logic [CNT_W-1:0] gr5;
    logic [CNT_W-1:0] gr0;
    logic             eq5_q, eq0_q;
    logic             mt5, mt0;
    logic             cap5, cap0;
    logic             capf5, capf0;
    logic [31:0]      gr5_mrg, gr0_mrg;

    // a function result cannot be part-selected, so merge into a net first
    assign gr5_mrg = merge(32'(gr5), w_data, w_strb);
    assign gr0_mrg = merge(32'(gr0), w_data, w_strb);

    // only the first cycle of equality counts, so a stalled counter
    // does not toggle the pin on every clock
    assign mt5  = is_oc(f5) && chan5_counter == gr5 && !eq5_q;
    assign mt0  = is_oc(f0) && chan0_counter == gr0 && !eq0_q;
    assign cap5 = f5[F_MODE] && cap_edge(f5, rise5, fall5);
    assign cap0 = f0[F_MODE] && (f0[F_LEVEL] ? chan1_count_tick
                : cap_edge(f0, rise0, fall0));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eq5_q <= 1'b0;
            eq0_q <= 1'b0;
        end else begin
            eq5_q <= chan5_counter == gr5;
            eq0_q <= chan0_counter == gr0;
        end
    end

    // capture wins over a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gr5 <= '0;
            gr0 <= '0;
        end else begin
            if (cap5)
                gr5 <= chan5_counter;
            else if (gr5_wr)
                gr5 <= gr5_mrg[CNT_W-1:0];
            if (cap0)
                gr0 <= chan0_counter;
            else if (gr0_wr)
                gr0 <= gr0_mrg[CNT_W-1:0];
        end
    end

    // sticky capture flags, write one to clear, a new capture wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capf5 <= 1'b0;
            capf0 <= 1'b0;
        end else begin
            capf5 <= cap5 || (capf5 && !(st_wr && w_data[ST_CAP5]));
            capf0 <= cap0 || (capf0 && !(st_wr && w_data[ST_CAP0]));
        end
    end

    // ========================================================
    // pin drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan5_pin_b_out  <= 1'b0;
            chan5_pin_b_oe_n <= 1'b1;
        end else if (cfg5_wr) begin
            chan5_pin_b_oe_n <= !is_oc(wf5);
            if (is_oc(wf5))
                chan5_pin_b_out <= wf5[F_LEVEL];
        end else if (mt5) begin
            chan5_pin_b_out <= oc_next(f5, chan5_pin_b_out);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan0_pin_a_out  <= 1'b0;
            chan0_pin_a_oe_n <= 1'b1;
        end else if (cfg0_wr) begin
            chan0_pin_a_oe_n <= !is_oc(wf0);
            if (is_oc(wf0))
                chan0_pin_a_out <= wf0[F_LEVEL];
        end else if (mt0) begin
            chan0_pin_a_out <= oc_next(f0, chan0_pin_a_out);
        end
    end

    // ========================================================
    // axi4-lite read channel
    logic [31:0] rd_mux;
    logic        ar_hs;
    logic        next_rvalid;

    assign ar_hs       = s_arvalid && s_arready;
    assign next_rvalid = ar_hs || (s_rvalid && !s_rready);

    always_comb begin
        rd_mux = '0;
        case (s_araddr)
            OFF_C5_IOC: rd_mux = 32'(ioc5);
            OFF_C0_IOC: rd_mux = 32'(ioc0);
            OFF_C5_GR:  rd_mux = 32'(gr5);
            OFF_C0_GR:  rd_mux = 32'(gr0);
            OFF_STAT: begin
                rd_mux[ST_CAP5] = capf5;
                rd_mux[ST_CAP0] = capf0;
                rd_mux[ST_PIN5] = pin5_s2;
                rd_mux[ST_PIN0] = pin0_s2;
                rd_mux[ST_OUT5] = chan5_pin_b_out;
                rd_mux[ST_OUT0] = chan0_pin_a_out;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= RESP_OKAY;
        end else begin
            s_arready <= !next_rvalid;
            s_rvalid  <= next_rvalid;
            if (ar_hs) begin
                s_rdata <= rd_mux;
                s_rresp <= is_mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_init_low: assert property (cfg5_wr && is_oc(wf5) && !wf5[F_LEVEL]
        |=> !chan5_pin_b_out && !chan5_pin_b_oe_n)
        else $error("initial low level not applied");
    a_out_off: assert property (cfg0_wr && !wf0[F_MODE]
        && fld_act(wf0) == ACT_NONE |=> chan0_pin_a_oe_n [*2])
        else $error("disabled output still driven");
    a_init_high: assert property (cfg0_wr && is_oc(wf0)
        && wf0[F_LEVEL] |=> chan0_pin_a_out && !chan0_pin_a_oe_n)
        else $error("initial high level not applied");
    a_match_low: assert property (mt5 && !cfg5_wr
        && fld_act(f5) == ACT_LOW |=> !chan5_pin_b_out)
        else $error("match did not drive low");
    a_match_high: assert property (mt0 && !cfg0_wr
        && fld_act(f0) == ACT_HIGH |=> chan0_pin_a_out)
        else $error("match did not drive high");
    a_match_toggle: assert property (mt5 && !cfg5_wr
        && fld_act(f5) == ACT_TOGGLE
        |=> chan5_pin_b_out != $past(chan5_pin_b_out))
        else $error("match did not toggle");
    a_cap_rise: assert property (f5[F_MODE] && fld_act(f5) == ACT_NONE
        && $rose(pin5_s2) |=> gr5 == $past(chan5_counter) && capf5)
        else $error("rising edge not captured");
    a_cap_fall: assert property (f0[F_MODE] && !f0[F_LEVEL]
        && fld_act(f0) == ACT_LOW && rise0 |=> !capf0 || $past(capf0))
        else $error("falling mode captured a rising edge");
    a_cap_both: assert property (f5[F_MODE] && f5[F_ACT_HI]
        && (rise5 || fall5) |=> capf5 && gr5 == $past(chan5_counter))
        else $error("both-edge capture missed");
    a_c5_level: assert property (f5[F_MODE] && f5[F_LEVEL]
        && fld_act(f5) == ACT_LOW && fall5 |=> gr5 == $past(chan5_counter))
        else $error("level bit blocked own pin capture");
    a_c0_pin: assert property (f0[F_MODE] && !f0[F_LEVEL]
        && fld_act(f0) == ACT_NONE && !rise0 && !gr0_wr
        |=> $stable(gr0))
        else $error("capture without own pin edge");
    a_c0_tick: assert property (f0[F_MODE] && f0[F_LEVEL]
        && chan1_count_tick |=> capf0 && gr0 == $past(chan0_counter))
        else $error("count tick not captured");
    a_hold_level: assert property (is_oc(f5) && !cfg5_wr && !mt5
        |=> $stable(chan5_pin_b_out) && !chan5_pin_b_oe_n)
        else $error("pin level moved without match");

    c_toggle: cover property (mt5 && fld_act(f5) == ACT_TOGGLE);
    c_tick_cap: cover property (cap0 && f0[F_LEVEL]);
    c_both_cap: cover property (cap5 && f5[F_ACT_HI] && fall5);
    c_bad_read: cover property (s_rvalid && s_rresp == RESP_SLVERR);
endmodule : tpc_top

// file: dv/tpc_pin_model.sv
// model of the external timer pin seen by one channel
`timescale 1ns/1ps
module tpc_pin_model (
    input  wire logic drv_out,
    input  wire logic drv_oe_n,
    input  wire logic ext_lvl,
    output logic      pin_lvl
);
    // the outside source takes the net whenever the channel lets go of it
    assign pin_lvl = drv_oe_n ? ext_lvl : drv_out;
endmodule : tpc_pin_model

// file: dv/timer_pin_io_control_tb.sv
// self-checking testbench for the timer pin i/o control block
`timescale 1ns/1ps
module timer_pin_io_control_tb;
    import tpc_pkg::*;
    logic        aclk, aresetn;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] c5, c0;
    logic        tick, e5, e0;
    logic        p5_in, p5_out, p5_oe_n, p0_in, p0_out, p0_oe_n;
    int          fails, num_checks, i;

    tpc_top #(.CNT_W(16)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rvalid), .s_rready(rready),
        .chan5_counter(c5), .chan0_counter(c0), .chan1_count_tick(tick),
        .chan5_pin_b_in(p5_in), .chan5_pin_b_out(p5_out),
        .chan5_pin_b_oe_n(p5_oe_n), .chan0_pin_a_in(p0_in),
        .chan0_pin_a_out(p0_out), .chan0_pin_a_oe_n(p0_oe_n)
    );
    tpc_pin_model u_pin5 (.drv_out(p5_out), .drv_oe_n(p5_oe_n),
        .ext_lvl(e5), .pin_lvl(p5_in));
    tpc_pin_model u_pin0 (.drv_out(p0_out), .drv_oe_n(p0_oe_n),
        .ext_lvl(e0), .pin_lvl(p0_in));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // ========================================================
    // reporting
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk

    task automatic hang(input string nm);
        $display("[FAIL] %s expected answer seen none", nm);
        fails++;
        finish_test();
    endtask : hang

    // ========================================================
    // bus master; ready lines stay high once raised
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] rs);
        int n;
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        rs = bresp;
        if (n == 64) hang("write response");
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        v  = rdata;
        rs = rresp;
        if (n == 64) hang("read response");
    endtask : bus_rd

    // ========================================================
    // scenarios
    task automatic oc(input bit ch, input logic [2:0] code);
        logic lvl;
        logic en;
        int   k;
        lvl = code[2];
        en  = code[1:0] != ACT_NONE;
        bus_wr(ch ? OFF_C0_GR : OFF_C5_GR, 32'h0000_0040, r);
        bus_wr(ch ? OFF_C0_IOC : OFF_C5_IOC,
               ch ? {28'h0, 1'b0, code} : {24'h0, 1'b0, code, 4'h0}, r);
        @(posedge aclk);
        chk("pin enable", 32'(!en), 32'(ch ? p0_oe_n : p5_oe_n));
        if (en) chk("initial level", 32'(lvl), 32'(ch ? p0_out : p5_out));
        for (k = 0; k < 2; k++) begin
            if (ch) c0 <= 16'h0040;
            else c5 <= 16'h0040;
            @(posedge aclk);
            c0 <= 16'h0000;
            c5 <= 16'h0000;
            repeat (2) @(posedge aclk);
            if (code[1:0] == ACT_TOGGLE) lvl = !lvl;
            else if (en) lvl = code[1:0] == ACT_HIGH;
            if (en) chk("match level", 32'(lvl), 32'(ch ? p0_out : p5_out));
        end
    endtask : oc

    task automatic cap(input bit ch, input logic lvl,
                       input logic [15:0] cnt, input logic [15:0] exp);
        if (ch) begin
            c0 <= cnt;
            e0 <= lvl;
        end else begin
            c5 <= cnt;
            e5 <= lvl;
        end
        repeat (6) @(posedge aclk);
        bus_rd(ch ? OFF_C0_GR : OFF_C5_GR, d, r);
        chk("captured count", 32'(exp), d);
    endtask : cap

    // ========================================================
    // main sequence
    initial begin
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {wdata, wstrb, c5, c0, tick, e5, e0} = '0;
        aresetn = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("reset enable", 32'h1, 32'({p5_oe_n, p0_oe_n} == 2'b11));
        bus_rd(OFF_C5_IOC, d, r);
        chk("ch5 control reset", 32'(IOC_RESET), d);
        bus_rd(OFF_C0_IOC, d, r);
        chk("ch0 control reset", 32'(IOC_RESET), d);
        bus_rd(8'h14, d, r);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
        bus_wr(8'h20, 32'h0000_00FF, r);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
        for (i = 0; i < 16; i++) oc(i[3], i[2:0]);
        bus_wr(OFF_C5_IOC, 32'h0000_0080, r);
        cap(1'b0, 1'b1, 16'h0011, 16'h0011);
        cap(1'b0, 1'b0, 16'h0022, 16'h0011);
        bus_wr(OFF_C5_IOC, 32'h0000_00D0, r);
        cap(1'b0, 1'b1, 16'h0033, 16'h0011);
        cap(1'b0, 1'b0, 16'h0044, 16'h0044);
        bus_wr(OFF_C5_IOC, 32'h0000_00E0, r);
        cap(1'b0, 1'b1, 16'h0055, 16'h0055);
        cap(1'b0, 1'b0, 16'h0066, 16'h0066);
        bus_wr(OFF_C0_IOC, 32'h0000_0008, r);
        cap(1'b1, 1'b1, 16'h0077, 16'h0077);
        cap(1'b1, 1'b0, 16'h0078, 16'h0077);
        bus_wr(OFF_C0_IOC, 32'h0000_0009, r);
        cap(1'b1, 1'b1, 16'h0079, 16'h0077);
        cap(1'b1, 1'b0, 16'h0088, 16'h0088);
        bus_wr(OFF_C0_IOC, 32'h0000_000B, r);
        cap(1'b1, 1'b1, 16'h0099, 16'h0099);
        bus_wr(OFF_C0_IOC, 32'h0000_000C, r);
        cap(1'b1, 1'b0, 16'h00AA, 16'h0099);
        tick <= 1'b1;
        c0   <= 16'h00BB;
        @(posedge aclk);
        tick <= 1'b0;
        c0   <= 16'h00CC;
        repeat (4) @(posedge aclk);
        bus_rd(OFF_C0_GR, d, r);
        chk("tick capture", 32'h0000_00BB, d);
        bus_rd(OFF_STAT, d, r);
        chk("status flags", 32'((1 << ST_CAP5) | (1 << ST_CAP0) |
            (1 << ST_OUT5) | (1 << ST_OUT0)), d);
        bus_wr(OFF_STAT, 32'h0000_0003, r);
        chk("status clear resp", 32'(RESP_OKAY), 32'(r));
        bus_rd(OFF_STAT, d, r);
        chk("status cleared", 32'((1 << ST_OUT5) | (1 << ST_OUT0)), d);
        finish_test();
    end
endmodule : timer_pin_io_control_tb
